/* File: bench/dual_updown_counter_gray_decoder_tb.sv */
// apb-driven bench for the dual counter block
module dual_updown_counter_gray_decoder_tb;
   import udc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, d;
   logic [2:0] p1, p2;
   int n_mismatch = 0, checks = 0;
   udc_pulse_src s1 (.clk(mclk), .p(p1));
   udc_pulse_src s2 (.clk(mclk), .p(p2));
   udc_counter u_dut (.MCLK(mclk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .COUNT_PULSE_IN_1(p1[2]), .DIR_SENSE_IN_1(p1[1]),
      .INDEX_CLEAR_IN_1(p1[0]), .COUNT_PULSE_IN_2(p2[2]), .DIR_SENSE_IN_2(p2[1]),
      .INDEX_CLEAR_IN_2(p2[0]));
   initial forever #12.5 mclk = ~mclk;
   task automatic print_verdict();
      if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", s, exp, got);
      end
   endtask
   // read data is taken at the very edge that samples ready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int i;
      @(posedge mclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
      @(posedge mclk) penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      d = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      if (i == 20) begin
         n_mismatch++;
         print_verdict();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string s);
      apb(1'b0, a, 32'h0);
      chk(s, d, exp);
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      rd(UDC_CTRL1_ADDR, 32'h08, "ctrl1");
      rd(8'h10, 32'h0, "unmapped");
      chk("slverr", {31'h0, e}, 32'h1);
      s1.pins(3'h2);
      s1.pulses(3);
      rd(UDC_VALUE0_ADDR, 32'h3, "f2 up");
      apb(1'b1, UDC_CTRL0_ADDR, 32'h0a);
      s1.pulses(5);
      rd(UDC_VALUE0_ADDR, 32'hfffffffe, "f2 down");
      apb(1'b1, UDC_CTRL0_ADDR, 32'h02);
      apb(1'b1, UDC_CTRL0_ADDR, 32'h0a);
      rd(UDC_VALUE0_ADDR, 32'h0, "sw clear");
      apb(1'b1, UDC_CTRL1_ADDR, 32'h09);
      s2.pulses(4);
      s2.pins(3'h2);
      s2.pulses(1);
      rd(UDC_VALUE1_ADDR, 32'h3, "f1 dir");
      s2.pins(3'h1);
      s2.pins(3'h0);
      rd(UDC_VALUE1_ADDR, 32'h0, "index clear");
      apb(1'b1, UDC_CTRL0_ADDR, 32'h06);
      // one bit changes per step of the reflected code
      for (int i = 0; i < 8; i++) begin
         s1.pins(3'(i ^ (i >> 1)));
         rd(UDC_VALUE0_ADDR, 32'(i ^ (i >> 1)), "decoder");
      end
      print_verdict();
   end
endmodule

/* File: bench/udc_counter_properties.sv */
// apb timing checks for the dual counter block
module udc_counter_properties
   import udc_pkg::*;
(
   // clock, reset and apb
   input wire logic                  MCLK,
   input wire logic                  RESET,
   input wire logic                  PSEL,
   input wire logic                  PENABLE,
   input wire logic                  PWRITE,
   input wire logic [UDC_ADDR_W-1:0] PADDR,
   input wire logic [UDC_DATA_W-1:0] PRDATA,
   input wire logic                  PREADY,
   input wire logic                  PSLVERR
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge MCLK); endclocking
   default disable iff (RESET);
   property p_late; $rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY; endproperty
   a_late: assert property (p_late) else $error("ready not in second access cycle");
   property p_pulse; PREADY |=> !PREADY; endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   property p_acc; PREADY |-> PSEL && PENABLE; endproperty
   a_acc: assert property (p_acc) else $error("ready outside access phase");
   property p_err; PSLVERR |-> PREADY; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_map; PREADY |-> PSLVERR == !(PADDR inside {8'h00, 8'h04, 8'h08, 8'h0c}); endproperty
   a_map: assert property (p_map) else $error("error flag wrong for address");
   property p_errd; PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0; endproperty
   a_errd: assert property (p_errd) else $error("refused read not zero");
   property p_top; PREADY && !PWRITE && !PADDR[2] |-> PRDATA[31:5] == 27'h0; endproperty
   a_top: assert property (p_top) else $error("control upper bits set");
   // read data only moves with ready, so software never sees a torn value
   property p_hold; !PREADY |-> $stable(PRDATA); endproperty
   a_hold: assert property (p_hold) else $error("read data moved without ready");
endmodule
bind udc_counter udc_counter_properties u_chk (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR));

/* File: bench/udc_pulse_src.sv */
// pulse source or rotary transducer on one counter's pins
module udc_pulse_src (
   // clock seen by the source
   input  wire logic       clk,
   // pins: count, direction, index
   output logic      [2:0] p
);
   timeunit 1ns;
   timeprecision 1ps;
   initial p = 3'h0;
   // each level held 4 cycles, above the 2-cycle minimum the synchroniser needs
   task automatic pins(input logic [2:0] v);
      @(posedge clk) p <= v;
      repeat (3) @(posedge clk);
   endtask
   // index stays low while counting, direction left as set
   task automatic pulses(input int n);
      repeat (n) begin
         pins({1'b1, p[1], 1'b0});
         pins({1'b0, p[1], 1'b0});
      end
   endtask
endmodule

/* File: core/udc_counter.sv */
// two counters with external or software direction, or a 3-bit reflected-code decoder
// Notes on behaviour
// RULE1: external direction mode set: count once per falling edge of count input.
// RULE2: external mode: direction input low counts up, high counts down.
// RULE3: external mode: source keeps the index input low while counting normally.
// RULE4: external mode: a high pulse on the index input clears the count.
// RULE5: software direction mode: still count on each falling edge of count input.
// RULE6: software mode: direction setting false counts up, true counts down.
// RULE7: software mode: the direction input pin is ignored.
// RULE8: software mode: clear comes from the software clear setting, active when low.
// RULE9: decoder setting true reads the three inputs as a 3-bit reflected code.
// RULE10: decoder mode ignores direction mode, software direction and software clear.
// RULE11: two counters, each with its own settings.
// RULE12: transducer changes only one input bit between positions.
// RULE13: decoder value is the raw 3-bit pattern read as binary.
// RULE14: inputs are synchronised and edges found on the synchronised count input.
//
// The register addresses and the APB slave port were chosen for this implementation.
module udc_counter
   import udc_pkg::*;
(
   // clock and reset
   input  wire logic                  MCLK,
   input  wire logic                  RESET,
   // apb slave
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [UDC_ADDR_W-1:0] PADDR,
   input  wire logic [UDC_DATA_W-1:0] PWDATA,
   output logic      [UDC_DATA_W-1:0] PRDATA,
   output logic                       PREADY,
   output logic                       PSLVERR,
   // counter 1 inputs
   input  wire logic                  COUNT_PULSE_IN_1,
   input  wire logic                  DIR_SENSE_IN_1,
   input  wire logic                  INDEX_CLEAR_IN_1,
   // counter 2 inputs
   input  wire logic                  COUNT_PULSE_IN_2,
   input  wire logic                  DIR_SENSE_IN_2,
   input  wire logic                  INDEX_CLEAR_IN_2
);

   // ---------------- input synchronisers ----------------
   logic [UDC_NUM_CNT-1:0] a_s1_r, a_s2_r, a_s3_r;
   logic [UDC_NUM_CNT-1:0] b_s1_r, b_s2_r;
   logic [UDC_NUM_CNT-1:0] z_s1_r, z_s2_r;
   logic [UDC_NUM_CNT-1:0] a_raw, b_raw, z_raw;

   assign a_raw = {COUNT_PULSE_IN_2, COUNT_PULSE_IN_1};
   assign b_raw = {DIR_SENSE_IN_2, DIR_SENSE_IN_1};
   assign z_raw = {INDEX_CLEAR_IN_2, INDEX_CLEAR_IN_1};

   // edge detection looks only at the second stage and its delayed copy
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         a_s1_r <= '0;
         a_s2_r <= '0;
         a_s3_r <= '0;
         b_s1_r <= '0;
         b_s2_r <= '0;
         z_s1_r <= '0;
         z_s2_r <= '0;
      end else begin
         a_s1_r <= a_raw;          // see RULE14
         a_s2_r <= a_s1_r;
         a_s3_r <= a_s2_r;
         b_s1_r <= b_raw;
         b_s2_r <= b_s1_r;
         z_s1_r <= z_raw;
         z_s2_r <= z_s1_r;
      end
   end

   // ---------------- registers and apb ----------------
   logic [UDC_CTRL_W-1:0] ctrl_r   [UDC_NUM_CNT];
   logic [UDC_CTRL_W-1:0] ctrl_nxt [UDC_NUM_CNT];
   logic [UDC_CNT_W-1:0]  value_r  [UDC_NUM_CNT];
   logic [UDC_CNT_W-1:0]  value_nxt[UDC_NUM_CNT];
   logic [UDC_DATA_W-1:0] prdata_r, prdata_nxt;
   logic                  pready_r, pready_nxt;
   logic                  pslverr_r, pslverr_nxt;
   logic                  acc_first, acc_done;

   function automatic logic addr_hit(input logic [UDC_ADDR_W-1:0] a);
      return (a == UDC_CTRL0_ADDR) || (a == UDC_VALUE0_ADDR) ||
             (a == UDC_CTRL1_ADDR) || (a == UDC_VALUE1_ADDR);
   endfunction

   function automatic logic [UDC_CNT_W-1:0] step(input logic [UDC_CNT_W-1:0] v,
                                                 input logic                  down);
      // wraps modulo the counter width in both directions
      return down ? v - UDC_CNT_W'(1) : v + UDC_CNT_W'(1);
   endfunction

   // one wait state: pready rises in the second access cycle
   assign acc_first = PSEL & PENABLE & ~pready_r;
   assign acc_done  = PSEL & PENABLE & pready_r;

   always_comb begin
      pready_nxt  = acc_first;
      pslverr_nxt = acc_first & ~addr_hit(PADDR);
      prdata_nxt  = prdata_r;
      if (acc_first) begin
         unique case (PADDR)
            UDC_CTRL0_ADDR:  prdata_nxt = UDC_DATA_W'(ctrl_r[0]);
            UDC_VALUE0_ADDR: prdata_nxt = value_r[0];
            UDC_CTRL1_ADDR:  prdata_nxt = UDC_DATA_W'(ctrl_r[1]);
            UDC_VALUE1_ADDR: prdata_nxt = value_r[1];
            default:         prdata_nxt = '0;
         endcase
      end
      for (int i = 0; i < UDC_NUM_CNT; i++) begin
         ctrl_nxt[i] = ctrl_r[i];
      end
      // writes land only on the edge that completes the access
      if (acc_done && PWRITE) begin
         if (PADDR == UDC_CTRL0_ADDR) begin
            ctrl_nxt[0] = PWDATA[UDC_CTRL_W-1:0];   // see RULE11
         end
         if (PADDR == UDC_CTRL1_ADDR) begin
            ctrl_nxt[1] = PWDATA[UDC_CTRL_W-1:0];   // see RULE11
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         prdata_r  <= '0;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         for (int i = 0; i < UDC_NUM_CNT; i++) begin
            ctrl_r[i] <= UDC_CTRL_RST;
         end
      end else begin
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         for (int i = 0; i < UDC_NUM_CNT; i++) begin
            ctrl_r[i] <= ctrl_nxt[i];
         end
      end
   end

   assign PRDATA  = prdata_r;
   assign PREADY  = pready_r;
   assign PSLVERR = pslverr_r;

   // ---------------- counting ----------------
   always_comb begin
      for (int i = 0; i < UDC_NUM_CNT; i++) begin
         value_nxt[i] = value_r[i];
         if (ctrl_r[i][UDC_DECODER_BIT]) begin
            // mode, direction and clear settings have no effect here; see RULE10
            value_nxt[i] = '0;
            value_nxt[i][UDC_GRAY_A_BIT] = a_s2_r[i];   // see RULE9
            value_nxt[i][UDC_GRAY_B_BIT] = b_s2_r[i];
            value_nxt[i][UDC_GRAY_Z_BIT] = z_s2_r[i];   // raw pattern, no decode; see RULE13
         end else if (ctrl_r[i][UDC_EXT_DIR_BIT]) begin
            // index pin is held low by the source while counting; see RULE3
            if (z_s2_r[i]) begin
               value_nxt[i] = '0;                        // see RULE4
            end else if (a_s3_r[i] && !a_s2_r[i]) begin
               value_nxt[i] = step(value_r[i], b_s2_r[i]);   // see RULE1 see RULE2
            end
         end else begin
            // direction pin not looked at in this mode; see RULE7
            if (!ctrl_r[i][UDC_CLEAR_N_BIT]) begin
               value_nxt[i] = '0;                        // see RULE8
            end else if (a_s3_r[i] && !a_s2_r[i]) begin
               value_nxt[i] = step(value_r[i], ctrl_r[i][UDC_SW_DOWN_BIT]);  // see RULE5 see RULE6
            end
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         for (int i = 0; i < UDC_NUM_CNT; i++) begin
            value_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < UDC_NUM_CNT; i++) begin
            value_r[i] <= value_nxt[i];
         end
      end
   end

endmodule

/* File: core/udc_pkg.sv */
// constants for the dual up/down counter and reflected-code decoder
package udc_pkg;
   localparam int          UDC_NUM_CNT     = 2;
   localparam int          UDC_CNT_W       = 32;
   localparam int          UDC_ADDR_W      = 8;
   localparam int          UDC_DATA_W      = 32;
   // register byte addresses, one block of two words per counter
   localparam logic [7:0]  UDC_CTRL0_ADDR  = 8'h00;
   localparam logic [7:0]  UDC_VALUE0_ADDR = 8'h04;
   localparam logic [7:0]  UDC_CTRL1_ADDR  = 8'h08;
   localparam logic [7:0]  UDC_VALUE1_ADDR = 8'h0c;
   // control register fields
   localparam int          UDC_EXT_DIR_BIT = 0;
   localparam int          UDC_SW_DOWN_BIT = 1;
   localparam int          UDC_DECODER_BIT = 2;
   localparam int          UDC_CLEAR_N_BIT = 3;
   localparam int          UDC_LEVEL_BIT   = 4;
   localparam int          UDC_CTRL_W      = 5;
   // reset value: function 2, count up, pulse mode, clear idle (high), 5 V inputs
   localparam logic [4:0]  UDC_CTRL_RST    = 5'h08;
   // decoder pattern bit positions: count, direction, index
   localparam int          UDC_GRAY_A_BIT  = 2;
   localparam int          UDC_GRAY_B_BIT  = 1;
   localparam int          UDC_GRAY_Z_BIT  = 0;
endpackage
